// >>> core/hds_pkg.sv
// shared constants for the host disk status register
package hds_pkg;
	// bit positions inside host_disk_state
	localparam int unsigned HDS_BIT_ERROR = 0;
	localparam int unsigned HDS_BIT_INDEX = 1;
	localparam int unsigned HDS_BIT_CORRECTED_DATA_FLAG = 2;
	localparam int unsigned HDS_BIT_XFER = 3;
	localparam int unsigned HDS_BIT_SEEK = 4;
	localparam int unsigned HDS_BIT_FAULT = 5;
	localparam int unsigned HDS_BIT_READY = 6;
	localparam int unsigned HDS_BIT_BUSY = 7;
	// register width
	localparam int unsigned HDS_WIDTH = 8;
	// reset values of the held flags
	localparam logic HDS_RST_BUSY = 1'b1;
	localparam logic HDS_RST_XFER = 1'b0;
	localparam logic HDS_RST_ERROR = 1'b0;
	localparam logic HDS_RST_CORRECTED_DATA_FLAG = 1'b0;
	localparam logic HDS_RST_INT = 1'b0;
	localparam logic [7:0] HDS_RST_STATE = 8'h80;
	// pin synchroniser depth and pin count
	localparam int unsigned HDS_SYNC_DEPTH = 3;
	localparam int unsigned HDS_NUM_PINS = 5;
	// pin slots in the synchroniser vector
	localparam int unsigned HDS_PIN_INDEX = 0;
	localparam int unsigned HDS_PIN_READY = 1;
	localparam int unsigned HDS_PIN_FAULT = 2;
	localparam int unsigned HDS_PIN_SEEK = 3;
	localparam int unsigned HDS_PIN_HRST = 4;
	// reset level of synchronised pins
	localparam logic [4:0] HDS_RST_PINS = 5'h00;
endpackage : hds_pkg

// >>> core/hds_status.sv
`timescale 1ns/1ps
// Summary of operation
// (R1) host may read status at any time
// (R2) host ignores other bits while busy
// (R3) status read clears pending host interrupt
// (R4) bit 0 flags error of last command
// (R5) bit 1 index, only while ready
// (R6) bit 2 flags corrected ecc data
// (R7) bit 3 set while data is to move
// (R8) occupied when transfer request or busy
// (R9) transfer request opens all host registers
// (R10) bit 4 mirrors drive seek complete
// (R11) bit 5 mirrors drive write fault
// (R12) bit 6 mirrors drive ready
// (R13) bit 7 set while command executes
// (R14) host limited to four registers while busy
// (R15) chip reset or host reset sets busy
// (R16) fixed-disk reset bit or command sets busy
// (R17) host reads error code only when idle
// (R18) microcontroller inputs set and clear flags
module hds_status
	import hds_pkg::*;
(
	// clock and chip reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// drive pins of the selected drive and host bus reset, asynchronous
	input wire logic drv_index,
	input wire logic drv_ready,
	input wire logic drv_write_fault,
	input wire logic drv_seek_done,
	input wire logic host_bus_reset,
	// host bus decode, same clock
	input wire logic host_status_rd,
	input wire logic host_cmd_wr,
	input wire logic host_fd_reset_bit,
	// microcontroller side, same clock
	input wire logic mc_busy_clr,
	input wire logic mc_xfer_set,
	input wire logic mc_xfer_clr,
	input wire logic mc_err_set,
	input wire logic mc_err_clr,
	input wire logic mc_corrected_data_flag_set,
	input wire logic mc_corrected_data_flag_clr,
	input wire logic mc_host_int_set,
	// status toward the host
	output logic [hds_pkg::HDS_WIDTH-1:0] host_disk_state,
	output logic host_int_pending,
	output logic ctrl_occupied,
	output logic host_regs_open
);
	import hds_pkg::*;

	// raw pin vector and its synchroniser stages
	logic [HDS_NUM_PINS-1:0] pin_raw;
	logic [HDS_NUM_PINS-1:0] pin_s1;
	logic [HDS_NUM_PINS-1:0] pin_s2;
	logic [HDS_NUM_PINS-1:0] pin_s3;
	logic [HDS_NUM_PINS-1:0] pin_val; // accepted pin levels
	logic [HDS_NUM_PINS-1:0] next_pin_val;

	// held flags
	logic busy;
	logic xfer_req;
	logic err_flag;
	logic corrected_data_flag;
	logic next_busy;
	logic next_xfer_req;
	logic next_err_flag;
	logic next_corrected_data_flag;
	logic next_host_int_pending;
	logic [HDS_WIDTH-1:0] next_host_disk_state;

	assign pin_raw[HDS_PIN_INDEX] = drv_index;
	assign pin_raw[HDS_PIN_READY] = drv_ready;
	assign pin_raw[HDS_PIN_FAULT] = drv_write_fault;
	assign pin_raw[HDS_PIN_SEEK] = drv_seek_done;
	assign pin_raw[HDS_PIN_HRST] = host_bus_reset;

	// three flops per pin; stage one feeds only stage two
	genvar gi;
	generate
		for (gi = 0; gi < HDS_NUM_PINS; gi++) begin : g_sync
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
			// a change counts once stages two and three agree
			always_comb begin
				next_pin_val[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_val[gi];
			end
		end
	endgenerate

	// accepted pin levels
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_val <= HDS_RST_PINS;
		end else begin
			pin_val <= next_pin_val;
		end
	end

	// next values of the held flags; every set wins over a clear
	always_comb begin
		next_busy = busy;
		next_xfer_req = xfer_req;
		next_err_flag = err_flag;
		next_corrected_data_flag = corrected_data_flag;
		next_host_int_pending = host_int_pending;
		// busy cleared by the microcontroller when a command ends
		if (mc_busy_clr) begin
			next_busy = 1'b0; // R18
		end
		// host reset, fixed-disk reset or new command start busy
		if (pin_val[HDS_PIN_HRST] || host_fd_reset_bit || host_cmd_wr) begin
			next_busy = 1'b1; // R15 R16 R13
		end
		// transfer request held while data is to move
		if (mc_xfer_clr) begin
			next_xfer_req = 1'b0; // R18
		end
		if (mc_xfer_set) begin
			next_xfer_req = 1'b1; // R7
		end
		// error of last command or diagnostics
		if (mc_err_clr) begin
			next_err_flag = 1'b0; // R18
		end
		if (mc_err_set) begin
			next_err_flag = 1'b1; // R4
		end
		// corrected ecc data on previous read
		if (mc_corrected_data_flag_clr) begin
			next_corrected_data_flag = 1'b0; // R18
		end
		if (mc_corrected_data_flag_set) begin
			next_corrected_data_flag = 1'b1; // R6
		end
		// a status read drops the pending interrupt unless a set arrives in the same cycle
		if (host_status_rd) begin
			next_host_int_pending = 1'b0; // R3
		end
		if (mc_host_int_set) begin
			next_host_int_pending = 1'b1;
		end
	end

	// status word assembled from flags and accepted pin levels
	always_comb begin
		next_host_disk_state = '0;
		next_host_disk_state[HDS_BIT_BUSY] = next_busy; // R13
		next_host_disk_state[HDS_BIT_READY] = next_pin_val[HDS_PIN_READY]; // R12
		next_host_disk_state[HDS_BIT_FAULT] = next_pin_val[HDS_PIN_FAULT]; // R11
		next_host_disk_state[HDS_BIT_SEEK] = next_pin_val[HDS_PIN_SEEK]; // R10
		next_host_disk_state[HDS_BIT_XFER] = next_xfer_req; // R7
		next_host_disk_state[HDS_BIT_CORRECTED_DATA_FLAG] = next_corrected_data_flag; // R6
		// index masked by ready
		next_host_disk_state[HDS_BIT_INDEX] =
			next_pin_val[HDS_PIN_INDEX] & next_pin_val[HDS_PIN_READY]; // R5
		next_host_disk_state[HDS_BIT_ERROR] = next_err_flag; // R4
	end

	// flag and status registers; reset starts busy
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= HDS_RST_BUSY; // R15
			xfer_req <= HDS_RST_XFER;
			err_flag <= HDS_RST_ERROR;
			corrected_data_flag <= HDS_RST_CORRECTED_DATA_FLAG;
			host_int_pending <= HDS_RST_INT;
			host_disk_state <= HDS_RST_STATE;
		end else begin
			busy <= next_busy;
			xfer_req <= next_xfer_req;
			err_flag <= next_err_flag;
			corrected_data_flag <= next_corrected_data_flag;
			host_int_pending <= next_host_int_pending;
			host_disk_state <= next_host_disk_state; // R1
		end
	end

	// occupied and register-gate indications for the host decode
	assign ctrl_occupied = busy | xfer_req; // R8
	assign host_regs_open = ~busy | xfer_req; // R9 R14

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	property p_rd_clears_int;
		host_status_rd && !mc_host_int_set |=> !host_int_pending;
	endproperty
	a_rd_clears_int: assert property (p_rd_clears_int) else $error("read left int pending"); // R3

	property p_int_set_wins;
		mc_host_int_set |=> host_int_pending;
	endproperty
	a_int_set_wins: assert property (p_int_set_wins) else $error("int set lost"); // R3

	property p_cmd_busy;
		host_cmd_wr |=> busy && host_disk_state[HDS_BIT_BUSY];
	endproperty
	a_cmd_busy: assert property (p_cmd_busy) else $error("command did not set busy"); // R16

	property p_fd_busy;
		host_fd_reset_bit |=> busy;
	endproperty
	a_fd_busy: assert property (p_fd_busy) else $error("fd reset did not set busy"); // R16

	property p_hrst_busy;
		host_bus_reset [*5] |=> busy;
	endproperty
	a_hrst_busy: assert property (p_hrst_busy) else $error("host reset did not set busy"); // R15

	property p_index_masked;
		!host_disk_state[HDS_BIT_READY] |-> !host_disk_state[HDS_BIT_INDEX];
	endproperty
	a_index_masked: assert property (p_index_masked) else $error("index while not ready"); // R5

	property p_ready_follows;
		drv_ready [*5] |-> host_disk_state[HDS_BIT_READY];
	endproperty
	a_ready_follows: assert property (p_ready_follows) else $error("ready not mirrored"); // R12

	property p_fault_follows;
		!drv_write_fault [*5] |-> !host_disk_state[HDS_BIT_FAULT];
	endproperty
	a_fault_follows: assert property (p_fault_follows) else $error("fault not mirrored"); // R11

	property p_seek_follows;
		drv_seek_done [*5] |-> host_disk_state[HDS_BIT_SEEK];
	endproperty
	a_seek_follows: assert property (p_seek_follows) else $error("seek not mirrored"); // R10

	property p_xfer_state;
		mc_xfer_set |=> host_disk_state[HDS_BIT_XFER] && ctrl_occupied && host_regs_open;
	endproperty
	a_xfer_state: assert property (p_xfer_state) else $error("transfer request wrong"); // R7 R8 R9

	property p_err_set;
		mc_err_set |=> host_disk_state[HDS_BIT_ERROR];
	endproperty
	a_err_set: assert property (p_err_set) else $error("error bit not set"); // R4

	property p_corrected_data_flag_set;
		mc_corrected_data_flag_set |=> host_disk_state[HDS_BIT_CORRECTED_DATA_FLAG];
	endproperty
	a_corrected_data_flag_set: assert property (p_corrected_data_flag_set) else $error("corrected_data_flag bit not set"); // R6

	property p_busy_clear;
		// accepted host reset level, not the raw pin, is what competes with the clear
		mc_busy_clr && !host_cmd_wr && !host_fd_reset_bit && !pin_val[HDS_PIN_HRST] |=> !busy;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared"); // R18

	c_cmd_then_clear: cover property (host_cmd_wr ##[1:20] !busy);
	c_read_clears: cover property (host_int_pending ##1 host_status_rd ##1 !host_int_pending);
	c_index_seen: cover property (host_disk_state[HDS_BIT_INDEX]);
endmodule : hds_status

// >>> verification/hds_host_model.sv
`timescale 1ns/1ps
// host side: issues status reads and command writes
module hds_host_model
	import hds_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// requests from the bench
	input wire logic want_rd,
	input wire logic want_cmd,
	// view of the device
	input wire logic [hds_pkg::HDS_WIDTH-1:0] host_disk_state,
	input wire logic host_regs_open,
	// host decode toward the device and the word kept from idle reads
	output logic host_status_rd,
	output logic host_cmd_wr,
	output logic [hds_pkg::HDS_WIDTH-1:0] last_valid
);
	logic [7:0] next_last_valid; // word kept from an idle read
	// reads always go out; command only while registers open
	assign host_status_rd = want_rd;
	assign host_cmd_wr = want_cmd & host_regs_open;
	// status bits are only trusted while not busy
	always_comb begin
		next_last_valid = last_valid;
		if (host_status_rd && !host_disk_state[HDS_BIT_BUSY]) begin
			next_last_valid = host_disk_state;
		end
	end
	// register the trusted word
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			last_valid <= 8'h00;
		end else begin
			last_valid <= next_last_valid;
		end
	end
endmodule : hds_host_model

// >>> verification/hds_status_bench.sv
`timescale 1ns/1ps
`define HDS_CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
	$display("CHECK FAILED t=%0t %s", $time, msg); end end
// random strobes against an integer reference of the status word
module hds_status_bench;
	import hds_pkg::*;
	logic sys_clk = 1'b0; // 40 mhz
	logic sys_rst = 1'b1; // chip reset
	logic [3:0] pins = 4'h0; // seek fault ready index
	logic [11:0] stim = 12'h000; // hrst int mc fd cmd rd
	logic rd, cmd_wr, regs_open, occupied, int_pend;
	logic [7:0] state, seen;
	logic [7:0] r_seen = 8'h00; // word the host should have kept from its last idle read
	int fail_count = 0, samples_checked = 0, cycles = 0;
	bit r_busy = 1, r_xfer, r_err, r_corrected_data_flag, r_int;
	always #12.5 sys_clk = ~sys_clk;
	hds_host_model host (.sys_clk(sys_clk), .sys_rst(sys_rst), .want_rd(stim[0]),
		.want_cmd(stim[1]), .host_disk_state(state), .host_regs_open(regs_open),
		.host_status_rd(rd), .host_cmd_wr(cmd_wr), .last_valid(seen));
	hds_status dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .drv_index(pins[0]),
		.drv_ready(pins[1]), .drv_write_fault(pins[2]), .drv_seek_done(pins[3]),
		.host_bus_reset(stim[11]), .host_status_rd(rd), .host_cmd_wr(cmd_wr),
		.host_fd_reset_bit(stim[2]), .mc_busy_clr(stim[3]), .mc_xfer_set(stim[4]),
		.mc_xfer_clr(stim[5]), .mc_err_set(stim[6]), .mc_err_clr(stim[7]),
		.mc_corrected_data_flag_set(stim[8]), .mc_corrected_data_flag_clr(stim[9]), .mc_host_int_set(stim[10]),
		.host_disk_state(state), .host_int_pending(int_pend), .ctrl_occupied(occupied),
		.host_regs_open(regs_open));
	// verdict and end of run
	task complete_run;
		$display("checks %0d failures %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// set wins over clear
	function automatic bit upd(bit old, bit set, bit clr);
		return set | (old & !clr);
	endfunction : upd
	// expected status word from the reference flags and settled pins
	function automatic logic [7:0] exp_word();
		return {r_busy, pins[1], pins[2], pins[3], r_xfer, r_corrected_data_flag, pins[0] & pins[1], r_err};
	endfunction : exp_word
	// reference step for the strobes sampled at this edge
	task ref_step(input logic [11:0] s);
		bit cmd;
		cmd = s[1] & (!r_busy | r_xfer);
		if (s[0] && !r_busy) r_seen = exp_word();
		r_busy = upd(r_busy, s[2] | cmd, s[3]);
		r_xfer = upd(r_xfer, s[4], s[5]);
		r_err = upd(r_err, s[6], s[7]);
		r_corrected_data_flag = upd(r_corrected_data_flag, s[8], s[9]);
		r_int = upd(r_int, s[10], s[0]);
	endtask : ref_step
	// compare all outputs with the reference
	task check_all;
		logic [7:0] e;
		e = exp_word();
		`HDS_CHK(state, e, "status word")
		`HDS_CHK(int_pend, r_int, "interrupt")
		`HDS_CHK(occupied, r_busy | r_xfer, "occupied")
		`HDS_CHK(regs_open, !r_busy | r_xfer, "registers open")
		`HDS_CHK(seen, r_seen, "host view")
	endtask : check_all
	// one clock: update reference, drive next stimulus, optionally compare
	task cycle(input logic [11:0] s, input bit chk);
		@(posedge sys_clk);
		ref_step(stim);
		stim <= s;
		#1;
		if (chk) check_all();
	endtask : cycle
	// sparse random strobes
	function automatic logic [11:0] rnd();
		logic [11:0] s;
		s = 12'h000;
		for (int i = 0; i < 11; i++) s[i] = ($urandom % 4 == 0);
		return s;
	endfunction : rnd
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			complete_run();
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'h0cb6));
		repeat (4) @(posedge sys_clk);
		#1 check_all();
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int ph = 0; ph < 8; ph++) begin
			// this edge samples the last strobes too, so the reference steps here
			@(posedge sys_clk);
			ref_step(stim);
			stim <= 12'h000;
			pins <= 4'($urandom);
			repeat (5) cycle(12'h000, 0);
			repeat (40) cycle(rnd(), 1);
		end
		cycle(12'h008, 1);
		cycle(12'h800, 1);
		repeat (6) cycle(12'h800, 0);
		r_busy = 1;
		check_all();
		repeat (6) cycle(12'h000, 0);
		check_all();
		// busy set by host reset stays until the microcontroller clears it
		cycle(12'h008, 0);
		cycle(12'h000, 1);
		complete_run();
	end
endmodule : hds_status_bench
